// ==== lcd_device.sv ====
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: Strap low enables power-on reset; high disables.
// R2: Host sends stop, start, address, soft reset.
// R3: Host waits for settled supply before commands.
// R4: Display off: frame-aligned, one off frame, ground.
// R5: Host keeps external clock running through shutdown.
// R6: 80 Hz: clock/512, host gives over 1024.
// R7: 71 Hz: clock/576, host gives over 1152.
// R8: 64 Hz: clock/648, host gives over 1296.
// R9: 53 Hz: clock/768, host gives over 1536.
// R10: Host avoids transfers while supply ramps.
// R11: Without reliable reset, host initialises early; the host's auto start never gets past go, so no early init.
// R12: Host avoids other devices while this unpowered.
module lcd_device #(
  parameter int OSC_DIV = 4,
  parameter int SEGS    = 36
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  lcd_link.device              link,
  input  wire logic            supply_good,
  input  wire logic            reset_disable_strap,
  output logic [SEGS-1:0]      seg_q,
  output logic [3:0]           com_q,
  output logic                 initialised_q,
  output logic                 display_on_q,
  output logic                 grounded_q
);
  if (OSC_DIV < 1 || OSC_DIV > 65535 || SEGS < 1) begin : g_bad
    $error("OSC_DIV must be 1..65535 and SEGS positive.");
  end

  typedef enum {R_IDLE, R_ADDR, R_CMD, R_DATA, R_SKIP} rx_type;
  typedef enum {D_OFF, D_ON, D_DRAIN, D_LAST} disp_type;

  // Pin synchronisers; a change counts once stages two and three agree.
  logic [2:0] sup_sync_q;
  logic [2:0] strap_sync_q;
  logic       sup_ok_q;
  logic       sup_ok_d;
  logic       strap_done_q;
  logic       strap_done_d;
  logic [1:0] fill_q;
  logic [1:0] fill_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_sync_q   <= 3'h0;
      strap_sync_q <= 3'h0;
    end else begin
      sup_sync_q   <= {sup_sync_q[1:0], supply_good};
      strap_sync_q <= {strap_sync_q[1:0], reset_disable_strap};
    end
  end

  always_comb begin
    sup_ok_d = sup_ok_q;
    if (sup_sync_q[1] == sup_sync_q[2]) begin
      sup_ok_d = sup_sync_q[2];
    end
    // The strap is trusted only once all three stages hold sampled pin data.
    fill_d       = (fill_q == 2'h3) ? fill_q : fill_q + 2'h1;
    strap_done_d = strap_done_q
                   | (fill_q == 2'h3 && strap_sync_q[1] == strap_sync_q[2]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_ok_q     <= 1'b0;
      strap_done_q <= 1'b0;
      fill_q       <= 2'h0;
    end else begin
      sup_ok_q     <= sup_ok_d;
      strap_done_q <= strap_done_d;
      fill_q       <= fill_d;
    end
  end

  // Two-wire receiver. An unpowered device neither acknowledges nor decodes.
  rx_type     rx_q;
  rx_type     rx_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic       ack_q;
  logic       ack_d;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       cmd_stb;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;

  always_comb begin
    rx_d    = rx_q;
    bits_d  = bits_q;
    shift_d = shift_q;
    ack_d   = ack_q;
    cmd_stb = 1'b0;
    start_c = link.scl & scl_p_q & sda_p_q & ~link.sda;
    stop_c  = link.scl & scl_p_q & ~sda_p_q & link.sda;
    rise_c  = link.scl & ~scl_p_q;
    fall_c  = ~link.scl & scl_p_q;
    if (!sup_ok_q) begin
      rx_d   = R_IDLE;
      ack_d  = 1'b0;
      bits_d = 4'h0;
    end else if (start_c) begin
      rx_d   = R_ADDR;
      bits_d = 4'h0;
      ack_d  = 1'b0;
    end else if (stop_c) begin
      rx_d  = R_IDLE;
      ack_d = 1'b0;
    end else if (rx_q != R_IDLE) begin
      if (rise_c && bits_q < 4'h9) begin
        bits_d = bits_q + 4'h1;
        if (bits_q < 4'h8) begin
          shift_d = {shift_q[6:0], link.sda};
        end
      end else if (fall_c && bits_q == 4'h8) begin
        case (rx_q)
          R_ADDR: begin
            if (shift_q == lcd_pkg::ADDR_BYTE) begin
              rx_d  = R_CMD;
              ack_d = 1'b1;
            end else begin
              rx_d = R_SKIP;
            end
          end
          R_CMD: begin
            ack_d = 1'b1;
            if (shift_q[lcd_pkg::CMD_BIT]) begin
              cmd_stb = 1'b1;
            end else begin
              rx_d = R_DATA;
            end
          end
          R_DATA: ack_d = 1'b1;
          default: ack_d = 1'b0;
        endcase
      end else if (fall_c && bits_q == 4'h9) begin
        ack_d  = 1'b0;
        bits_d = 4'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q    <= R_IDLE;
      bits_q  <= 4'h0;
      shift_q <= 8'h00;
      ack_q   <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      rx_q    <= rx_d;
      bits_q  <= bits_d;
      shift_q <= shift_d;
      ack_q   <= ack_d;
      scl_p_q <= link.scl;
      sda_p_q <= link.sda;
    end
  end

  assign link.dev_sda_oe = ack_q;

  // Configuration, frame timing and the display state.
  disp_type                dst_q;
  disp_type                dst_d;
  logic                    ext_mode_q;
  logic                    ext_mode_d;
  lcd_pkg::frame_rate_type fr_q;
  lcd_pkg::frame_rate_type fr_d;
  logic [15:0]             osc_q;
  logic [15:0]             osc_d;
  logic [9:0]              qcnt_q;
  logic [9:0]              qcnt_d;
  logic [1:0]              cidx_q;
  logic [1:0]              cidx_d;
  logic                    pol_q;
  logic                    pol_d;
  logic                    ext_p_q;
  logic                    init_d;
  logic [SEGS-1:0]         seg_d;
  logic [3:0]              com_d;
  logic                    tick;
  logic                    frame_end;
  logic [9:0]              quarter;

  always_comb begin
    dst_d      = dst_q;
    ext_mode_d = ext_mode_q;
    fr_d       = fr_q;
    init_d     = initialised_q;
    qcnt_d     = qcnt_q;
    cidx_d     = cidx_q;
    pol_d      = pol_q;
    osc_d      = (osc_q == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_q + 16'h0001;
    // In external mode the frame advances only on host clock edges.
    tick      = ext_mode_q ? (link.ext_clk & ~ext_p_q)
                           : (osc_q == 16'(OSC_DIV - 1)); // see R5
    quarter   = lcd_pkg::frame_div(fr_q) >> 2; // see R6 see R7 see R8 see R9
    frame_end = tick && qcnt_q == quarter - 10'h001 && cidx_q == 2'h3;
    if (!strap_done_q && strap_done_d) begin
      init_d = ~strap_sync_q[2]; // see R1
    end
    if (dst_q != D_OFF && tick) begin
      if (qcnt_q == quarter - 10'h001) begin
        qcnt_d = 10'h000;
        cidx_d = cidx_q + 2'h1;
        if (cidx_q == 2'h3) begin
          pol_d = ~pol_q;
        end
      end else begin
        qcnt_d = qcnt_q + 10'h001;
      end
    end
    case (dst_q)
      D_DRAIN: if (frame_end) dst_d = D_LAST; // see R4
      D_LAST:  if (frame_end) dst_d = D_OFF; // see R4
      default: dst_d = dst_q;
    endcase
    if (cmd_stb) begin
      if ((shift_q & lcd_pkg::CMD_MASK_CFG) == lcd_pkg::CMD_CFG) begin
        if (shift_q[lcd_pkg::CFG_RESET_BIT]) begin
          init_d     = 1'b1;
          dst_d      = D_OFF;
          fr_d       = lcd_pkg::FR_80;
        end
        if (init_d) begin
          ext_mode_d = shift_q[lcd_pkg::CFG_EXT_BIT];
        end
      end else if (!initialised_q) begin
        dst_d = dst_q;
      end else if ((shift_q & lcd_pkg::CMD_MASK_3) == lcd_pkg::CMD_CONTROL) begin
        fr_d = lcd_pkg::frame_rate_type'(shift_q[4:3]);
      end else if ((shift_q & lcd_pkg::CMD_MASK_3) == lcd_pkg::CMD_MODE) begin
        if (shift_q[lcd_pkg::MODE_ON_BIT]) begin
          dst_d = D_ON;
        end else if (dst_q == D_ON) begin
          dst_d = D_DRAIN; // see R4
        end
      end
    end
    if (dst_q == D_OFF && dst_d == D_ON) begin
      qcnt_d = 10'h000;
      cidx_d = 2'h0;
    end
    // Outputs follow the next state so that they leave flip-flops directly.
    com_d = (dst_d == D_OFF) ? 4'h0 : 4'h1 << cidx_d;
    seg_d = (dst_d == D_ON || dst_d == D_DRAIN) ? {SEGS{pol_d}}
                                                : {SEGS{1'b0}}; // see R4
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_q         <= D_OFF;
      ext_mode_q    <= 1'b0;
      fr_q          <= lcd_pkg::FR_80;
      osc_q         <= 16'h0000;
      qcnt_q        <= 10'h000;
      cidx_q        <= 2'h0;
      pol_q         <= 1'b0;
      ext_p_q       <= 1'b0;
      initialised_q <= 1'b0;
      seg_q         <= {SEGS{1'b0}};
      com_q         <= 4'h0;
      display_on_q  <= 1'b0;
      grounded_q    <= 1'b1;
    end else begin
      dst_q         <= dst_d;
      ext_mode_q    <= ext_mode_d;
      fr_q          <= fr_d;
      osc_q         <= osc_d;
      qcnt_q        <= qcnt_d;
      cidx_q        <= cidx_d;
      pol_q         <= pol_d;
      ext_p_q       <= link.ext_clk;
      initialised_q <= init_d;
      seg_q         <= seg_d;
      com_q         <= com_d;
      display_on_q  <= (dst_d == D_ON);
      grounded_q    <= (dst_d == D_OFF); // see R4
    end
  end
endmodule
`default_nettype wire

// ==== lcd_pkg.sv ====
`default_nettype none
package lcd_pkg;
  // Address byte with the write bit, followed by command encodings.
  localparam logic [7:0] ADDR_BYTE     = 8'h7c;
  localparam logic [7:0] CMD_MASK_CFG  = 8'hf8;
  localparam logic [7:0] CMD_CFG       = 8'he8;
  localparam logic [7:0] CMD_MASK_3    = 8'he0;
  localparam logic [7:0] CMD_MODE      = 8'hc0;
  localparam logic [7:0] CMD_CONTROL   = 8'ha0;
  localparam int         CFG_EXT_BIT   = 0;
  localparam int         CFG_RESET_BIT = 1;
  localparam int         MODE_ON_BIT   = 3;
  localparam int         CMD_BIT       = 7;

  typedef enum logic [1:0] {FR_80, FR_71, FR_64, FR_53} frame_rate_type;
  localparam logic [9:0] DIV_80 = 10'h200;
  localparam logic [9:0] DIV_71 = 10'h240;
  localparam logic [9:0] DIV_64 = 10'h288;
  localparam logic [9:0] DIV_53 = 10'h300;

  function automatic logic [9:0] frame_div(frame_rate_type fr);
    case (fr)
      FR_80:   frame_div = DIV_80;
      FR_71:   frame_div = DIV_71;
      FR_64:   frame_div = DIV_64;
      default: frame_div = DIV_53;
    endcase
  endfunction

  // Supply settling time before any transfer.
  localparam int SUPPLY_SETTLE_US = 100;
  localparam int CLK_MHZ          = 100;
  localparam int SETTLE_CYCLES    = SUPPLY_SETTLE_US * CLK_MHZ;

  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam int          CTRL_INIT   = 0;
  localparam int          CTRL_ON     = 1;
  localparam int          CTRL_OFF    = 2;
  localparam int          CTRL_EXT    = 3;
  localparam int          CTRL_FR_LSB = 4;
  localparam int          CTRL_AUTO   = 6;
  localparam logic [31:0] CTRL_RESET  = 32'h00000040;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_SETTLED  = 1;
  localparam int          ST_NACK     = 2;
  localparam int          ST_EXT_RUN  = 3;
  localparam int          ST_OTHER_OK = 4;
endpackage
`default_nettype wire

// ==== lcd_link.sv ====
`timescale 1ns/100ps
`default_nettype none
interface lcd_link;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;
  logic ext_clk;

  // Open-drain data line: any enabled driver pulls it low.
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (
    output scl,
    output host_sda_oe,
    output ext_clk,
    input  sda
  );
  modport device (
    input  scl,
    input  sda,
    input  ext_clk,
    output dev_sda_oe
  );
endinterface
`default_nettype wire

// ==== lcd_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcd_host #(
  parameter int SETTLE_CYCLES = lcd_pkg::SETTLE_CYCLES,
  parameter int BIT_DIV       = 4,
  parameter int EXT_HALF      = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  input  wire logic        supply_good,
  output logic             other_bus_ok_q,
  lcd_link.host            link
);
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || BIT_DIV < 1
      || BIT_DIV > 255 || EXT_HALF < 1 || EXT_HALF > 255) begin : g_bad
    $error("Host timing parameters out of range.");
  end

  typedef enum {OP_INIT, OP_ON, OP_OFF} op_type;
  typedef enum {H_IDLE, H_STOP_A, H_STOP_B, H_STOP_C, H_START_A, H_START_B,
                H_BIT_L, H_BIT_H, H_BIT_N, H_DRAIN} hst_type;

  function automatic logic [7:0] seq_byte(op_type op, logic [2:0] idx,
                                          logic ext,
                                          lcd_pkg::frame_rate_type fr);
    seq_byte = lcd_pkg::ADDR_BYTE;
    if (idx != 3'h0) begin
      if (op == OP_INIT) begin
        seq_byte = lcd_pkg::CMD_CFG | (8'h01 << lcd_pkg::CFG_RESET_BIT);
      end else if (idx == 3'h1) begin
        seq_byte = lcd_pkg::CMD_CFG | {7'h00, ext};
      end else if (op == OP_ON && idx == 3'h2) begin
        seq_byte = lcd_pkg::CMD_CONTROL | {3'h0, fr, 3'h0};
      end else if (op == OP_ON) begin
        seq_byte = lcd_pkg::CMD_MODE | (8'h01 << lcd_pkg::MODE_ON_BIT);
      end else begin
        seq_byte = lcd_pkg::CMD_MODE;
      end
    end
  endfunction

  hst_type                 hs_q, hs_d;
  op_type                  op_q, op_d;
  logic [2:0]              byte_q, byte_d;
  logic [3:0]              bit_q, bit_d;
  logic                    first_q, first_d;
  logic [10:0]             drain_q, drain_d;
  logic [7:0]              tdiv_q, tdiv_d;
  logic [7:0]              ediv_q, ediv_d;
  logic                    scl_q, scl_d, sda_oe_q, sda_oe_d;
  logic                    ext_clk_q, ext_clk_d, ext_run_q, ext_run_d;
  logic                    nack_q, nack_d;
  logic [15:0]             settle_q, settle_d;
  logic                    settled_q, settled_d;
  logic                    ext_mode_q, ext_mode_d, auto_q, auto_d;
  lcd_pkg::frame_rate_type fr_q, fr_d;
  logic [31:0]             prdata_d;
  logic [2:0]              sup_sync_q;
  logic                    sup_ok_q, sup_ok_d;
  logic                    wr, tick, ext_rise, go;
  logic [2:0]              go_bits;
  logic [7:0]              cur;

  always_comb begin
    hs_d = hs_q;
    op_d = op_q;
    {byte_d, bit_d, first_d} = {byte_q, bit_q, first_q};
    {drain_d, scl_d, sda_oe_d, ext_run_d} = {drain_q, scl_q, sda_oe_q, ext_run_q};
    {ext_mode_d, auto_d} = {ext_mode_q, auto_q};
    fr_d = fr_q;
    sup_ok_d  = (sup_sync_q[1] == sup_sync_q[2]) ? sup_sync_q[2] : sup_ok_q;
    tick      = (tdiv_q == 8'(BIT_DIV - 1));
    tdiv_d    = tick ? 8'h00 : tdiv_q + 8'h01;
    ediv_d    = (!ext_run_q || ediv_q == 8'(EXT_HALF - 1)) ? 8'h00
                                                            : ediv_q + 8'h01;
    ext_clk_d = ext_run_q ? ext_clk_q ^ (ediv_q == 8'(EXT_HALF - 1)) : 1'b0;
    ext_rise  = ext_clk_d & ~ext_clk_q;
    // Supply must hold good for the settling time before any transfer.
    settle_d  = sup_ok_q ? settle_q : 16'h0000; // see R3 see R10
    settled_d = sup_ok_q && settle_q == 16'(SETTLE_CYCLES - 1);
    if (sup_ok_q && !settled_d) begin
      settle_d = settle_q + 16'h0001;
    end
    wr      = psel & penable & pready_q & pwrite;
    go_bits = (wr && paddr == lcd_pkg::CTRL_OFS) ? pwdata[2:0] : 3'h0;
    nack_d  = nack_q & ~(wr && paddr == lcd_pkg::STATUS_OFS
                         && pwdata[lcd_pkg::ST_NACK]);
    if (wr && paddr == lcd_pkg::CTRL_OFS) begin
      ext_mode_d = pwdata[lcd_pkg::CTRL_EXT];
      fr_d = lcd_pkg::frame_rate_type'(pwdata[lcd_pkg::CTRL_FR_LSB +: 2]);
      auto_d = pwdata[lcd_pkg::CTRL_AUTO];
    end
    // Settling just completed with auto start: request init, but go still needs settled_q, so the request is dropped.
    if (auto_q && settled_d && !settled_q) begin
      go_bits[lcd_pkg::CTRL_INIT] = 1'b1; // see R11
    end
    go  = (go_bits != 3'h0) && hs_q == H_IDLE && settled_q; // see R3 see R10
    cur = seq_byte(op_q, byte_q, ext_mode_q, fr_q);
    if (hs_q == H_IDLE) begin
      if (go) begin
        op_d = go_bits[lcd_pkg::CTRL_INIT] ? OP_INIT
             : go_bits[lcd_pkg::CTRL_ON] ? OP_ON : OP_OFF;
        first_d = go_bits[lcd_pkg::CTRL_INIT];
        {byte_d, bit_d} = 7'h00;
        hs_d = first_d ? H_STOP_A : H_START_A; // see R2
        if (op_d == OP_INIT) begin
          ext_run_d = 1'b0;
        end else if (op_d == OP_ON && ext_mode_d) begin
          ext_run_d = 1'b1;
        end
      end
    end else if (hs_q == H_DRAIN) begin
      if (ext_rise) begin
        drain_d = drain_q + 11'h001;
        if (drain_q == {lcd_pkg::frame_div(fr_q), 1'b0}) begin
          ext_run_d = 1'b0; // see R5 see R6 see R7 see R8 see R9
          hs_d = H_IDLE;
        end
      end
    end else if (tick) begin
      case (hs_q)
        H_STOP_A: begin
          {scl_d, sda_oe_d} = 2'b01;
          hs_d = H_STOP_B;
        end
        H_STOP_B: begin
          scl_d = 1'b1;
          hs_d  = H_STOP_C;
        end
        H_STOP_C: begin
          sda_oe_d = 1'b0;
          first_d  = 1'b0;
          hs_d = first_q ? H_START_A
               : (op_q == OP_OFF && ext_run_q) ? H_DRAIN : H_IDLE;
          drain_d = 11'h000;
        end
        H_START_A: begin
          {scl_d, sda_oe_d} = 2'b10;
          hs_d = H_START_B;
        end
        H_START_B: begin
          sda_oe_d = 1'b1;
          hs_d     = H_BIT_L;
        end
        H_BIT_L: begin
          scl_d    = 1'b0;
          sda_oe_d = (bit_q == 4'h8) ? 1'b0 : ~cur[3'h7 - bit_q[2:0]];
          hs_d     = H_BIT_H;
        end
        H_BIT_H: begin
          scl_d = 1'b1;
          hs_d  = H_BIT_N;
        end
        H_BIT_N: begin
          hs_d  = H_BIT_L;
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h8) begin
            nack_d = nack_d | link.sda;
            bit_d  = 4'h0;
            byte_d = byte_q + 3'h1;
            if (byte_q == ((op_q == OP_INIT) ? 3'h1
                         : (op_q == OP_ON) ? 3'h3 : 3'h2)) begin
              hs_d = H_STOP_A;
            end
          end
        end
        default: hs_d = H_IDLE;
      endcase
    end
    prdata_d = 32'h00000000;
    if (psel && !penable && !pwrite) begin
      if (paddr == lcd_pkg::CTRL_OFS) begin
        prdata_d = {25'h0, auto_q, fr_q, ext_mode_q, 3'h0};
      end else if (paddr == lcd_pkg::STATUS_OFS) begin
        prdata_d = {27'h0, sup_ok_q, ext_run_q, nack_q, settled_q,
                    hs_q != H_IDLE};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q <= H_IDLE;
      op_q <= OP_INIT;
      {byte_q, bit_q, first_q, drain_q} <= 19'h00000;
      {tdiv_q, ediv_q} <= 16'h0000;
      {scl_q, sda_oe_q, ext_clk_q, ext_run_q} <= 4'b1000;
      {nack_q, settle_q, settled_q} <= 18'h00000;
      ext_mode_q     <= lcd_pkg::CTRL_RESET[lcd_pkg::CTRL_EXT];
      auto_q         <= lcd_pkg::CTRL_RESET[lcd_pkg::CTRL_AUTO];
      fr_q           <= lcd_pkg::FR_80;
      {prdata_q, pready_q, pslverr_q} <= 34'h000000000;
      {sup_sync_q, sup_ok_q, other_bus_ok_q} <= 5'h00;
    end else begin
      hs_q <= hs_d;
      op_q <= op_d;
      {byte_q, bit_q, first_q, drain_q} <= {byte_d, bit_d, first_d, drain_d};
      {tdiv_q, ediv_q} <= {tdiv_d, ediv_d};
      {scl_q, sda_oe_q, ext_clk_q, ext_run_q} <=
        {scl_d, sda_oe_d, ext_clk_d, ext_run_d};
      {nack_q, settle_q, settled_q} <= {nack_d, settle_d, settled_d};
      {ext_mode_q, auto_q} <= {ext_mode_d, auto_d};
      fr_q <= fr_d;
      prdata_q  <= prdata_d;
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & paddr != lcd_pkg::CTRL_OFS
                   & paddr != lcd_pkg::STATUS_OFS;
      sup_sync_q <= {sup_sync_q[1:0], supply_good};
      sup_ok_q   <= sup_ok_d;
      // Other bus users wait while the display driver is unpowered.
      other_bus_ok_q <= sup_ok_d; // see R12
    end
  end

  assign link.scl         = scl_q;
  assign link.host_sda_oe = sda_oe_q;
  assign link.ext_clk     = ext_clk_q;
endmodule
`default_nettype wire

// ==== lcd_reset_and_display_off_sequencer_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcd_reset_and_display_off_sequencer_checker #(
  parameter int SEGS = 36
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            scl,
  input wire logic            host_sda_oe,
  input wire logic            dev_sda_oe,
  input wire logic            sda,
  input wire logic            supply_good,
  input wire logic [SEGS-1:0] seg_q,
  input wire logic [3:0]      com_q,
  input wire logic            display_on_q,
  input wire logic            grounded_q,
  input wire logic            other_bus_ok_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_grounding;
    !grounded_q ##1 grounded_q;
  endsequence
  sequence s_unpowered;
    !supply_good [*8];
  endsequence
  AST_SDA_WIRE: assert property (
    sda == ~(host_sda_oe | dev_sda_oe)) else $error("data line level wrong");
  AST_SCL_HOLD: assert property (
    $changed(scl) |=> $stable(scl) [*3]) else $error("clock line too short");
  AST_GROUND: assert property (
    grounded_q |-> seg_q == '0 && com_q == 4'h0) else $error("not grounded");
  AST_OFF_FRAME: assert property (
    s_grounding |-> $past(com_q) != 4'h0 && $past(seg_q) == '0)
    else $error("no off frame before ground");
  AST_COM_ONEHOT: assert property (
    com_q != 4'h0 |-> $onehot(com_q)) else $error("common phase not one-hot");
  AST_ON_LIFTS: assert property (
    $rose(display_on_q) |-> ##[0:2] !grounded_q) else $error("stuck grounded");
  AST_BUS_OK: assert property (
    $fell(supply_good) |-> ##[1:6] !other_bus_ok_q) else $error("bus ok late");
  AST_SILENT: assert property (
    s_unpowered |-> !dev_sda_oe) else $error("unpowered device drives data");
endmodule
`default_nettype wire

// ==== test_lcd_reset_and_display_off_sequencer.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_lcd_reset_and_display_off_sequencer;
  logic        pclk, presetn, psel, penable, pwrite, supply_good, strap;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_q, r;
  logic        pready_q, pslverr_q, other_bus_ok_q, e;
  logic [35:0] seg_q;
  logic [3:0]  com_q;
  logic        initialised_q, display_on_q, grounded_q, scl_p, sda_p;
  int          mismatches, n_checks, starts, stops, rises;
  int          divs[4] = '{512, 576, 648, 768};
  lcd_link link();
  lcd_host #(.SETTLE_CYCLES(20)) i_lcd_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .supply_good(supply_good),
    .other_bus_ok_q(other_bus_ok_q), .link(link));
  lcd_device i_lcd_device (.pclk(pclk), .presetn(presetn), .link(link),
    .supply_good(supply_good), .reset_disable_strap(strap), .seg_q(seg_q),
    .com_q(com_q), .initialised_q(initialised_q),
    .display_on_q(display_on_q), .grounded_q(grounded_q));
  lcd_reset_and_display_off_sequencer_checker i_checker (.pclk(pclk),
    .presetn(presetn), .scl(link.scl), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .supply_good(supply_good),
    .seg_q(seg_q), .com_q(com_q), .display_on_q(display_on_q),
    .grounded_q(grounded_q), .other_bus_ok_q(other_bus_ok_q));
  // Bus conditions are counted on the wire itself, not taken from the host.
  always @(posedge pclk) begin
    if (scl_p && link.scl && sda_p && !link.sda) starts++;
    if (scl_p && link.scl && !sda_p && link.sda) stops++;
    scl_p <= link.scl;
    sda_p <= link.sda;
  end
  always @(posedge link.ext_clk) rises++;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    r = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // Busy is polled over the bus, so the wait costs bus cycles, not edges.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, lcd_pkg::STATUS_OFS, 32'h0);
      n++;
    end while (r[lcd_pkg::ST_BUSY] !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    strap <= s;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_good, strap} = 2'b11;
    do_reset(1'b1);
    apb(1'b1, lcd_pkg::CTRL_OFS, 32'h0);
    repeat (40) @(posedge pclk);
    chk(initialised_q === 1'b0, "strap high still reset");
    {starts, stops} = '0;
    apb(1'b1, lcd_pkg::CTRL_OFS, 32'h1);
    wait_idle();
    chk(initialised_q === 1'b1, "soft reset missing");
    chk(starts == 1 && stops == 2, "stop start order");
    do_reset(1'b0);
    repeat (10) @(posedge pclk);
    chk(initialised_q === 1'b1, "power-on reset missing");
    repeat (40) @(posedge pclk);
    wait_idle();
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, lcd_pkg::CTRL_OFS, 32'h0a | (f << 4));
      wait_idle();
      chk(display_on_q === 1'b1 && grounded_q === 1'b0, "not on");
      rises = 0;
      apb(1'b1, lcd_pkg::CTRL_OFS, 32'h0c | (f << 4));
      wait_idle();
      chk(rises > 2 * divs[f], "external clock too short");
      chk(grounded_q === 1'b1 && com_q === 4'h0, "outputs not grounded");
    end
    apb(1'b0, 8'h10, 32'h0);
    chk(e === 1'b1 && r === 32'h0, "unmapped access accepted");
    supply_good <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(other_bus_ok_q === 1'b0, "bus open while unpowered");
    apb(1'b1, lcd_pkg::CTRL_OFS, 32'h2);
    repeat (20) @(posedge pclk);
    chk(display_on_q === 1'b0, "command taken on bad supply");
    apb(1'b0, lcd_pkg::STATUS_OFS, 32'h0);
    chk(r[lcd_pkg::ST_BUSY] === 1'b0 && r[lcd_pkg::ST_SETTLED] === 1'b0, "busy on bad supply");
    tally_and_finish();
  end
  initial begin
    #800us;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
